/* rtl/fpc_pkg.sv */
// Package for the feeding roll position control block.
// Assumes a 20 MHz pclk and an APB master with 32-bit data.
package fpc_pkg;
   // APB register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;   // Run and trim commands
   localparam logic [7:0] OFF_CIRC = 8'h04;   // Roll circumference
   localparam logic [7:0] OFF_PPR = 8'h08;    // Pulses per revolution
   localparam logic [7:0] OFF_GAIN = 8'h0c;   // Proportional gain
   localparam logic [7:0] OFF_ITIME = 8'h10;  // Integration time, ms
   localparam logic [7:0] OFF_TRIM = 8'h14;   // Trim time, ms per step
   localparam logic [7:0] OFF_DIV = 8'h18;    // Correction divider
   localparam logic [7:0] OFF_LIM = 8'h1c;    // Correction limit, mV
   localparam logic [7:0] OFF_RAMP = 8'h20;   // Ramp time, s
   localparam logic [7:0] OFF_MODE = 8'h24;   // Dancer mode
   localparam logic [7:0] OFF_ERR = 8'h28;    // Error counter, RO
   localparam logic [7:0] OFF_CORR = 8'h2c;   // Correction out, RO
   localparam logic [7:0] OFF_SPEED = 8'h30;  // Ramp level, RO
   // Control bit positions
   localparam int CTRL_RUN = 0;
   localparam int CTRL_TRF = 1;
   localparam int CTRL_TRR = 2;
   // Setting ranges
   localparam logic [31:0] CIRC_MAX = 32'h1869f;   // 99999
   localparam logic [31:0] PPR_MAX = 32'hf423f;    // 999999
   localparam logic [31:0] GAIN_MAX = 32'h270f;    // 9999
   localparam logic [31:0] ITIME_MAX = 32'h3e8;    // 1000 ms
   localparam logic [31:0] TRIM_MAX = 32'h3e7;     // 999 ms
   localparam logic [31:0] DIV_MAX = 32'h1f;       // 31
   localparam logic [31:0] LIM_MAX = 32'h270f;     // 9999 mV
   localparam logic [31:0] RAMP_MAX = 32'h3e7;     // 999 s
   localparam logic [31:0] MODE_MAX = 32'h2;
   localparam logic [4:0] DIV_MIN = 5'h01;
   // Reset values
   localparam logic [13:0] GAIN_RST = 14'h03e8;
   localparam logic [9:0] TRIM_RST = 10'h001;
   localparam logic [4:0] DIV_RST = 5'h01;
   localparam logic [13:0] LIM_RST = 14'h270f;
   localparam logic [9:0] RAMP_RST = 10'h014;
   // Timing: ms tick from the clock period
   localparam int CLK_NS = 50;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / CLK_NS;
   // Ramp level full scale, per mille of max speed
   localparam logic [9:0] SPEED_FULL = 10'h3e8;
   // Gain scaling: mV = error * gain >> P_SHIFT
   localparam int P_SHIFT = 10;
   typedef enum logic [1:0] {
      MODE_POS = 2'b00,
      MODE_DINC = 2'b01,
      MODE_DDEC = 2'b10
   } fpc_mode_e;
   typedef enum logic [1:0] {
      RAMP_IDLE = 2'b00,
      RAMP_UP = 2'b01,
      RAMP_RUN = 2'b10,
      RAMP_DOWN = 2'b11
   } fpc_ramp_e;
   typedef struct packed {
      logic [16:0] circ;
      logic [19:0] ppr;
      logic [13:0] gain;
      logic [9:0] itime;
      logic [9:0] trim;
      logic [4:0] div;
      logic [13:0] lim;
      logic [9:0] ramp;
      logic [1:0] mode;
      logic run;
      logic trf;
      logic trr;
   } fpc_cfg_s;
endpackage : fpc_pkg

/* rtl/fpc_feed_ctrl.sv */
// Feeding roll position control with APB setting registers.
// Assumes encoder and schedule steps as synchronous one-cycle pulses
// and a dancer signal already digitised in mV.
// What this block does
// RL1: Circumference zero disables the feed axis
// RL2: Pulses per revolution zero disables axis
// RL3: Correction scaled by gain, 0 to 9999
// RL4: Integration time zero means pure proportional
// RL5: Trim moves one increment per trim time
// RL6: Divider sets window and error division
// RL7: No correction inside the backlash window
// RL8: Clamp correction, error counter never saturates
// RL9: Operator keeps limit above 1000 mV; the block accepts any limit from 0 to 9999 mV
// RL10: Ramp speed on start and stop
// RL11: Mode zero counts encoder pulses for position
// RL12: Dancer modes disable the differential counter
// RL13: Dancer sign selects speed-up direction
// RL14: Sum P and I; hold I in window
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fpc_feed_ctrl
   import fpc_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC  // Clock cycles per millisecond
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enc_step,
   input wire logic enc_dir,
   input wire logic sched_step,
   input wire logic sched_dir,
   input wire logic signed [14:0] dancer_in,
   output logic signed [14:0] corr_mv,
   output logic [9:0] speed_pm,
   output logic axis_on
);
   localparam int MS_W = $clog2(MS_CYCLES);

   // Address decode, shared by write strobe and error answer
   function automatic logic addr_ok(input logic [7:0] a);
      return (a <= OFF_SPEED) && (a[1:0] == 2'h0);
   endfunction : addr_ok

   // Limit a written value to the top of its range
   function automatic logic [31:0] sat(input logic [31:0] v,
                                       input logic [31:0] m);
      return (v > m) ? m : v;
   endfunction : sat

   // Clamp a wide correction to plus or minus the limit
   function automatic logic signed [14:0] clamp_corr(
      input logic signed [47:0] v, input logic [13:0] lim);
      logic signed [47:0] l;
      logic signed [47:0] nl;
      l = $signed({34'h0, lim});
      nl = -l;
      if (v > l) begin
         return l[14:0];
      end else if (v < nl) begin
         return nl[14:0];
      end
      return v[14:0];
   endfunction : clamp_corr

   fpc_cfg_s cfg_reg, cfg_next;        // Setting registers
   logic [31:0] prdata_reg, prdata_next; // Read data
   logic [MS_W-1:0] ms_cnt_reg, ms_cnt_next; // Millisecond divider
   logic ms_tick;                       // One pulse per ms
   logic [9:0] trim_cnt_reg, trim_cnt_next; // Trim ms counter
   logic trim_step;                     // Trim increment now
   logic signed [31:0] err_reg, err_next; // Position error count
   logic signed [31:0] delta;           // Error change this cycle
   logic signed [47:0] integ_reg, integ_next; // Integral term
   logic signed [31:0] win;             // Backlash half-window
   logic signed [31:0] err_abs;         // Error magnitude
   logic signed [31:0] e_div;           // Divided error
   logic in_win;                        // Error inside window
   logic signed [47:0] p_raw;           // Error times gain
   logic signed [47:0] corr_raw;        // Unclamped correction
   logic signed [14:0] corr_reg, corr_next; // Correction out
   fpc_ramp_e ramp_st_reg, ramp_st_next; // Ramp state
   logic [9:0] speed_reg, speed_next;   // Speed level
   logic [9:0] ramp_cnt_reg, ramp_cnt_next; // ms per level
   logic ramp_adv;                      // Level step now
   logic run_req;                       // Feeder asked to run
   logic pos_mode;                      // Encoder counting mode
   logic apb_wr;                        // Write access phase

   assign axis_on = (cfg_reg.circ != 17'h0) // RL1
                  && (cfg_reg.ppr != 20'h0); // RL2
   assign pos_mode = (cfg_reg.mode == MODE_POS); // RL11
   assign pready = 1'b1;                 // Zero wait states
   assign pslverr = psel && penable && !addr_ok(paddr);
   assign prdata = prdata_reg;
   assign corr_mv = corr_reg;
   assign speed_pm = speed_reg;
   assign apb_wr = psel && penable && pwrite && addr_ok(paddr);
   assign run_req = cfg_reg.run && axis_on;

   // Register writes, each value held inside its range
   always_comb begin
      cfg_next = cfg_reg;
      if (apb_wr) begin
         unique case (paddr)
            OFF_CTRL: begin
               cfg_next.run = pwdata[CTRL_RUN];
               cfg_next.trf = pwdata[CTRL_TRF];
               cfg_next.trr = pwdata[CTRL_TRR];
            end
            OFF_CIRC: cfg_next.circ = 17'(sat(pwdata, CIRC_MAX));
            OFF_PPR: cfg_next.ppr = 20'(sat(pwdata, PPR_MAX));
            OFF_GAIN: cfg_next.gain = 14'(sat(pwdata, GAIN_MAX)); // RL3
            OFF_ITIME: cfg_next.itime = 10'(sat(pwdata, ITIME_MAX));
            OFF_TRIM: cfg_next.trim = 10'(sat(pwdata, TRIM_MAX));
            OFF_DIV: begin
               cfg_next.div = 5'(sat(pwdata, DIV_MAX));
               // Setting 0 would mean a negative shift
               if (cfg_next.div < DIV_MIN) begin
                  cfg_next.div = DIV_MIN;
               end
            end
            OFF_LIM: cfg_next.lim = 14'(sat(pwdata, LIM_MAX)); // RL8
            OFF_RAMP: cfg_next.ramp = 10'(sat(pwdata, RAMP_MAX));
            OFF_MODE: cfg_next.mode = 2'(sat(pwdata, MODE_MAX));
            default: ;                     // Status offsets read only
         endcase
      end
   end

   // Read data captured in the setup phase
   always_comb begin
      prdata_next = prdata_reg;
      if (psel && !penable) begin
         unique case (paddr)
            OFF_CTRL: prdata_next = {29'h0, cfg_reg.trr, cfg_reg.trf,
                                     cfg_reg.run};
            OFF_CIRC: prdata_next = {15'h0, cfg_reg.circ};
            OFF_PPR: prdata_next = {12'h0, cfg_reg.ppr};
            OFF_GAIN: prdata_next = {18'h0, cfg_reg.gain};
            OFF_ITIME: prdata_next = {22'h0, cfg_reg.itime};
            OFF_TRIM: prdata_next = {22'h0, cfg_reg.trim};
            OFF_DIV: prdata_next = {27'h0, cfg_reg.div};
            OFF_LIM: prdata_next = {18'h0, cfg_reg.lim};
            OFF_RAMP: prdata_next = {22'h0, cfg_reg.ramp};
            OFF_MODE: prdata_next = {30'h0, cfg_reg.mode};
            OFF_ERR: prdata_next = err_reg;
            OFF_CORR: prdata_next = 32'(corr_reg);
            OFF_SPEED: prdata_next = {22'h0, speed_reg};
            default: prdata_next = 32'h0;  // Unmapped reads zero
         endcase
      end
   end

   // Millisecond tick for trim, integral and ramp timing
   always_comb begin
      ms_tick = (ms_cnt_reg == MS_W'(MS_CYCLES - 1));
      ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 1'b1;
   end

   // Trim: one increment per trim time while a command holds
   always_comb begin
      trim_cnt_next = trim_cnt_reg;
      trim_step = 1'b0;
      if (cfg_reg.trf == cfg_reg.trr) begin
         trim_cnt_next = 10'h0;            // Both or none: no trim
      end else if (ms_tick) begin
         trim_cnt_next = trim_cnt_reg + 10'h1;
         if (trim_cnt_next >= cfg_reg.trim) begin // RL5
            trim_step = 1'b1;
            trim_cnt_next = 10'h0;
         end
      end
   end

   // Error counter wraps instead of saturating
   always_comb begin
      delta = 32'sh0;
      if (sched_step) begin
         delta = sched_dir ? -32'sh1 : 32'sh1;
      end
      if (enc_step) begin
         delta = enc_dir ? delta + 32'sh1 : delta - 32'sh1; // RL11
      end
      if (trim_step) begin
         delta = cfg_reg.trr ? delta - 32'sh1 : delta + 32'sh1;
      end
      err_next = err_reg + delta;       // RL8
      // Dancer modes and a disabled axis hold no error
      if (!pos_mode || !axis_on) begin
         err_next = 32'sh0;                // RL12
      end
   end

   // Divider window and P plus I correction
   always_comb begin
      win = (32'sh1 <<< (cfg_reg.div - DIV_MIN)) - 32'sh1; // RL6
      err_abs = (err_reg < 32'sh0) ? -err_reg : err_reg;
      in_win = (err_abs <= win);
      e_div = err_reg >>> (cfg_reg.div - DIV_MIN); // RL6
      p_raw = 48'(e_div) * $signed({34'h0, cfg_reg.gain}); // RL3
      integ_next = integ_reg;
      if (!pos_mode || cfg_reg.itime == 10'h0) begin
         integ_next = 48'sh0;              // RL4
      end else if (ms_tick && !in_win) begin
         // Short time constant gives a large per-ms step
         integ_next = integ_reg + p_raw / $signed({38'h0, cfg_reg.itime});
      end
      // Inside the window the integral simply holds
      if (pos_mode) begin
         corr_raw = in_win ? 48'sh0 // RL7
                  : (p_raw + integ_reg) >>> P_SHIFT; // RL14
      end else if (cfg_reg.mode == MODE_DINC) begin
         corr_raw = 48'(dancer_in);        // RL13
      end else begin
         corr_raw = -48'(dancer_in);       // RL13
      end
      corr_next = clamp_corr(corr_raw, cfg_reg.lim); // RL8
      // A stopped or disabled feeder gets no correction
      if (!axis_on || ramp_st_reg == RAMP_IDLE) begin
         corr_next = 15'sh0;
      end
   end

   // Ramp: one per-mille step every ramp-time ms
   always_comb begin
      ramp_st_next = ramp_st_reg;
      speed_next = speed_reg;
      ramp_cnt_next = ramp_cnt_reg;
      ramp_adv = 1'b0;
      if (cfg_reg.ramp == 10'h0) begin
         ramp_adv = 1'b1;                  // Zero time: jump at once
      end else if (ms_tick) begin
         ramp_cnt_next = ramp_cnt_reg + 10'h1;
         if (ramp_cnt_next >= cfg_reg.ramp) begin
            ramp_adv = 1'b1;
            ramp_cnt_next = 10'h0;
         end
      end
      unique case (ramp_st_reg)
         RAMP_IDLE: begin
            ramp_cnt_next = 10'h0;
            if (run_req) begin
               ramp_st_next = RAMP_UP;
            end
         end
         RAMP_UP: begin
            if (!run_req) begin
               ramp_st_next = RAMP_DOWN;
            end else if (ramp_adv) begin  // RL10
               speed_next = (cfg_reg.ramp == 10'h0) ? SPEED_FULL
                          : speed_reg + 10'h1;
               if (speed_next == SPEED_FULL) begin
                  ramp_st_next = RAMP_RUN;
               end
            end
         end
         RAMP_RUN: begin
            if (!run_req) begin
               ramp_st_next = RAMP_DOWN;
            end
         end
         RAMP_DOWN: begin
            if (run_req) begin
               ramp_st_next = RAMP_UP;
            end else if (ramp_adv) begin  // RL10
               speed_next = (cfg_reg.ramp == 10'h0) ? 10'h0
                          : speed_reg - 10'h1;
               if (speed_next == 10'h0) begin
                  ramp_st_next = RAMP_IDLE;
               end
            end
         end
      endcase
   end

   // All state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= '{circ: 17'h0, ppr: 20'h0, gain: GAIN_RST,
                      itime: 10'h0, trim: TRIM_RST, div: DIV_RST,
                      lim: LIM_RST, ramp: RAMP_RST, mode: MODE_POS,
                      run: 1'b0, trf: 1'b0, trr: 1'b0};
         prdata_reg <= 32'h0;
         ms_cnt_reg <= '0;
         trim_cnt_reg <= 10'h0;
         err_reg <= 32'sh0;
         integ_reg <= 48'sh0;
         corr_reg <= 15'sh0;
         ramp_st_reg <= RAMP_IDLE;
         speed_reg <= 10'h0;
         ramp_cnt_reg <= 10'h0;
      end else begin
         cfg_reg <= cfg_next;
         prdata_reg <= prdata_next;
         ms_cnt_reg <= ms_cnt_next;
         trim_cnt_reg <= trim_cnt_next;
         err_reg <= err_next;
         integ_reg <= integ_next;
         corr_reg <= corr_next;
         ramp_st_reg <= ramp_st_next;
         speed_reg <= speed_next;
         ramp_cnt_reg <= ramp_cnt_next;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Write of a gain setting, then the stored value
   sequence gain_wr_s;
      apb_wr && paddr == OFF_GAIN && pwdata > GAIN_MAX;
   endsequence
   sequence start_s;
      ramp_st_reg == RAMP_IDLE && run_req && cfg_reg.ramp == 10'h0;
   endsequence

   circ_off_a: assert property (cfg_reg.circ == 17'h0 |-> !axis_on) // RL1
      else $error("axis on with zero circumference");
   ppr_off_a: assert property (cfg_reg.ppr == 20'h0 |=> // RL2
      corr_mv == 15'sh0 && err_reg == 32'sh0)
      else $error("axis active with zero pulses per rev");
   gain_sat_a: assert property (gain_wr_s |=> // RL3
      cfg_reg.gain == 14'(GAIN_MAX))
      else $error("gain not held at its maximum");
   integ_off_a: assert property (cfg_reg.itime == 10'h0 |=> // RL4
      integ_reg == 48'sh0)
      else $error("integral active with zero time");
   trim_tick_a: assert property (trim_step |-> ms_tick // RL5
      && (cfg_reg.trf != cfg_reg.trr))
      else $error("trim step off the ms tick");
   win_zero_a: assert property (pos_mode && in_win && axis_on // RL7
      |=> corr_mv == 15'sh0)
      else $error("correction inside backlash window");
   clamp_lim_a: assert property (##1 (corr_mv <= // RL8
      $signed({1'b0, $past(cfg_reg.lim)}))
      && (corr_mv >= -$signed({1'b0, $past(cfg_reg.lim)})))
      else $error("correction beyond limit");
   ramp_jump_a: assert property (start_s ##1 run_req // RL10
      |=> speed_pm == SPEED_FULL)
      else $error("zero ramp did not jump to full");
   dancer_err_a: assert property (!pos_mode |=> err_reg == 32'sh0) // RL12
      else $error("error counter runs in dancer mode");
   dancer_dir_a: assert property (cfg_reg.mode == MODE_DDEC // RL13
      && dancer_in < 15'sh0 && cfg_reg.lim != 14'h0 && axis_on
      && ramp_st_reg != RAMP_IDLE |=> corr_mv > 15'sh0)
      else $error("dancer direction wrong");
   win_hold_a: assert property (pos_mode && in_win // RL14
      && cfg_reg.itime != 10'h0 |=> $stable(integ_reg))
      else $error("integral moved inside window");
endmodule : fpc_feed_ctrl
`default_nettype wire

/* tb/fpc_roll_model.sv */
// Behavioural feeding roll encoder and speed-controlled drive.
// Assumes corr_mv and speed_pm from the position control block.
`timescale 1ns/100ps
`default_nettype none
module fpc_roll_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic follow,
   input wire logic signed [14:0] corr_mv,
   input wire logic [9:0] speed_pm,
   output logic enc_step,
   output logic enc_dir
);
   logic [2:0] gap_reg; // Spacing between encoder increments
   // Spacing of eight cycles lets the correction settle, so no overshoot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_reg <= 3'h0;
         enc_step <= 1'b0;
         enc_dir <= 1'b0;
      end else begin
         gap_reg <= gap_reg + 3'h1;
         enc_step <= 1'b0;
         enc_dir <= ~enc_dir; // Direction carries nothing between steps
         if (follow && speed_pm != 10'h000 && corr_mv != 15'sh0000 &&
             gap_reg == 3'h0) begin
            enc_step <= 1'b1;
            enc_dir <= corr_mv[14]; // Positive correction turns forward
         end
      end
   end
endmodule : fpc_roll_model
`default_nettype wire

/* tb/fpc_feed_ctrl_tb_top.sv */
// Self-checking bench for the feeding roll position control.
// Assumes MS_CYCLES of 20, so one millisecond is 20 clocks.
`timescale 1ns/100ps
`default_nettype none
module feed_roll_position_control_tb_top;
   import fpc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, e0;
   logic enc_step, enc_dir, sched_step, sched_dir, axis_on, follow, er;
   logic signed [14:0] dancer_in, corr_mv;
   logic [9:0] speed_pm;
   int n_errors = 0; // Mismatches
   int comparisons = 0; // Checks made
   // Register reset values in offset order
   logic [31:0] rst_tbl [10] = '{32'h0, 32'h0, 32'h0, 32'h3e8, 32'h0,
      32'h1, 32'h1, 32'h270f, 32'h14, 32'h0};
   fpc_feed_ctrl #(.MS_CYCLES(20)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .enc_step(enc_step), .enc_dir(enc_dir),
      .sched_step(sched_step), .sched_dir(sched_dir),
      .dancer_in(dancer_in), .corr_mv(corr_mv), .speed_pm(speed_pm),
      .axis_on(axis_on));
   fpc_roll_model roll (.pclk(pclk), .presetn(presetn), .follow(follow),
      .corr_mv(corr_mv), .speed_pm(speed_pm), .enc_step(enc_step),
      .enc_dir(enc_dir));
   // Free-running 20 MHz clock
   always #25 pclk = ~pclk;
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait for the slave's answer
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk); // Idle edge keeps strobes single-assigned
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rd_chk
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask : cyc
   // Correction lands one edge after its cause; allow settling
   task automatic chk_corr(input string what, input logic [31:0] exp);
      cyc(3);
      chk(what, exp, corr_mv);
   endtask : chk_corr
   // Scheduled increments, one per cycle
   task automatic steps(input int n);
      sched_dir <= 1'b0;
      sched_step <= 1'b1;
      cyc(n);
      sched_step <= 1'b0;
      cyc(4);
   endtask : steps
   // Watchdog well beyond the under two thousand cycles the tests need
   initial begin
      #(30000 * 50);
      n_errors++;
      $display("BAD watchdog expected finish seen hang");
      final_report();
   end
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, sched_step, sched_dir, follow} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      dancer_in = 15'sh0000;
      cyc(4);
      presetn <= 1'b1;
      cyc(1);
      for (int i = 0; i < 10; i++) begin
         rd_chk("reset value", 8'(4 * i), rst_tbl[i]);
      end
      chk("axis off", 32'h0, {31'h0, axis_on});
      apb(1'b0, 8'h34, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      chk("unmapped read", 32'h0, rd);
      wr(OFF_CIRC, 32'hffffffff);
      rd_chk("circ sat", OFF_CIRC, CIRC_MAX);
      wr(OFF_PPR, 32'hffffffff);
      rd_chk("ppr sat", OFF_PPR, PPR_MAX);
      chk("axis on", 32'h1, {31'h0, axis_on});
      wr(OFF_CIRC, 32'h0);
      chk("circ zero", 32'h0, {31'h0, axis_on});
      wr(OFF_CIRC, 32'h1);
      wr(OFF_PPR, 32'h0);
      chk("ppr zero", 32'h0, {31'h0, axis_on});
      wr(OFF_PPR, 32'h4);
      wr(OFF_GAIN, 32'hffff);
      rd_chk("gain sat", OFF_GAIN, GAIN_MAX);
      wr(OFF_DIV, 32'h0);
      rd_chk("div zero", OFF_DIV, 32'h1);
      wr(OFF_GAIN, 32'h400); // Unit gain: one mV per increment
      wr(OFF_RAMP, 32'h0);
      wr(OFF_CTRL, 32'h1);
      cyc(2); // Jump edge, then one spare edge
      chk("ramp jump", 32'h3e8, {22'h0, speed_pm});
      steps(5);
      rd_chk("err count", OFF_ERR, 32'h5);
      chk_corr("p corr", 32'h5);
      wr(OFF_DIV, 32'h3);
      chk_corr("div 4", 32'h1);
      wr(OFF_DIV, 32'h4);
      chk_corr("window 7", 32'h0);
      steps(11);
      wr(OFF_DIV, 32'h5);
      chk_corr("div 16", 32'h1);
      wr(OFF_DIV, 32'h1);
      wr(OFF_LIM, 32'h3);
      chk_corr("clamp", 32'h3);
      rd_chk("err past clamp", OFF_ERR, 32'h10);
      wr(OFF_LIM, 32'h270f);
      wr(OFF_DIV, 32'h5);
      wr(OFF_ITIME, 32'h1);
      cyc(100);
      chk("i grows", 32'h1, {31'h0, corr_mv > 15'sd2});
      wr(OFF_DIV, 32'h6);
      chk_corr("i window", 32'h0);
      wr(OFF_DIV, 32'h5);
      cyc(3);
      chk("i held", 32'h1, {31'h0, corr_mv > 15'sd2});
      wr(OFF_ITIME, 32'h0);
      chk_corr("p only", 32'h1);
      wr(OFF_MODE, 32'h1);
      dancer_in <= 15'sd100;
      chk_corr("dancer up", 32'h64);
      steps(3);
      rd_chk("counter off", OFF_ERR, 32'h0);
      wr(OFF_MODE, 32'h2);
      chk_corr("dancer down", 32'hffffff9c);
      dancer_in <= -15'sd100;
      chk_corr("dancer neg", 32'h64);
      dancer_in <= 15'sh0000;
      wr(OFF_MODE, 32'h0);
      wr(OFF_DIV, 32'h1);
      wr(OFF_LIM, 32'h3);
      wr(OFF_CTRL, 32'h5);
      cyc(220);
      wr(OFF_CTRL, 32'h1);
      apb(1'b0, OFF_ERR, 32'h0); // Fetch count
      chk("trim rev", 32'h1, {31'h0, $signed(rd) <= -10 &&
         $signed(rd) >= -12});
      chk_corr("neg clamp", 32'hfffffffd);
      wr(OFF_TRIM, 32'h2);
      apb(1'b0, OFF_ERR, 32'h0);
      e0 = rd;
      wr(OFF_CTRL, 32'h3);
      cyc(400);
      wr(OFF_CTRL, 32'h1);
      apb(1'b0, OFF_ERR, 32'h0);
      chk("trim fwd", 32'h1, {31'h0, rd - e0 >= 32'h9 &&
         rd - e0 <= 32'hb});
      wr(OFF_CTRL, 32'h0);
      cyc(2); // Drop edge, then one spare edge
      chk("ramp stop", 32'h0, {22'h0, speed_pm});
      wr(OFF_RAMP, 32'h1);
      wr(OFF_CTRL, 32'h1);
      cyc(200);
      chk("ramp up", 32'h1, {31'h0, speed_pm >= 10'h009 &&
         speed_pm <= 10'h00c});
      wr(OFF_RAMP, 32'h0);
      wr(OFF_MODE, 32'h1); // Clears the counter
      wr(OFF_MODE, 32'h0);
      wr(OFF_LIM, 32'h270f);
      follow <= 1'b1;
      steps(20);
      cyc(400);
      rd_chk("loop closed", OFF_ERR, 32'h0);
      final_report();
   end
endmodule : feed_roll_position_control_tb_top
`default_nettype wire
